// File: hw/adcc_pkg.sv
`default_nettype none
package adcc_pkg;
    localparam int          DATA_BITS        = 10;
    localparam int          WORD_BITS        = 16;
    // register offsets on the special-function port
    localparam logic [7:0]  OFS_PAIR_CFG     = 8'hBA;
    localparam logic [7:0]  OFS_CONV_CFG     = 8'hBC;
    localparam logic [7:0]  OFS_CONV_CTL     = 8'hE8;
    localparam logic [7:0]  RST_PAIR_CFG     = 8'h00;
    localparam logic [7:0]  RST_CONV_CFG     = 8'h60;
    localparam logic [7:0]  RST_CONV_CTL     = 8'h00;
    // converter_config fields
    localparam int          CFG_SAR_LSB      = 5;
    localparam int          CFG_GAIN_LSB     = 0;
    // converter_control bit positions
    localparam int          CTL_ENABLE       = 7;
    localparam int          CTL_TRACK_MODE   = 6;
    localparam int          CTL_DONE         = 5;
    localparam int          CTL_BUSY         = 4;
    localparam int          CTL_STM_LSB      = 2;
    localparam int          CTL_WINDOW       = 1;
    localparam int          CTL_LJST         = 0;
    // start_trigger_mode codes
    localparam logic [1:0]  STM_SOFTWARE     = 2'h0;
    localparam logic [1:0]  STM_TIMER3       = 2'h1;
    localparam logic [1:0]  STM_PIN          = 2'h2;
    localparam logic [1:0]  STM_TIMER2       = 2'h3;
    // timing: track length in SAR clocks, longest SAR period in system clocks
    localparam logic [1:0]  TRACK_SAR_CLKS   = 2'h3;
    localparam logic [4:0]  SAR_MAX_PERIOD   = 5'h10;
endpackage
`default_nettype wire

// File: hw/adcc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adcc_link_if;
    logic [2:0]  sar_code;
    logic        enable;
    logic        sar_tick;
    logic [9:0]  raw;
    logic        diff;
    logic        ljst;
    logic [15:0] gt_limit;
    logic [15:0] lt_limit;
    logic [15:0] word;
    logic        hit;

    modport clkgen (input sar_code, input enable, output sar_tick);
    modport fmt    (input raw, input diff, input ljst, input gt_limit, input lt_limit, output word, output hit);
    modport ctrl   (output sar_code, output enable, output raw, output diff, output ljst,
                    output gt_limit, output lt_limit, input sar_tick, input word, input hit);
endinterface
`default_nettype wire

// File: hw/adcc_sar_clkgen.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_sar_clkgen
    import adcc_pkg::*;
(
    input  wire logic   ref_clk,
    input  wire logic   srst,
    adcc_link_if.clkgen lnk
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       tick;
    } adcc_clk_st_t;

    adcc_clk_st_t st_r;
    adcc_clk_st_t st_nxt;
    logic [4:0]   period;

    always_comb
    begin
        // codes 1xx all give the longest period
        if (lnk.sar_code[2])
            period = SAR_MAX_PERIOD;
        else
            period = 5'(5'h1 << lnk.sar_code[1:0]);
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!lnk.enable)
        begin
            st_nxt.cnt = 4'h0;
        end
        else if ({1'b0, st_r.cnt} >= period - 5'h1)
        begin
            st_nxt.cnt  = 4'h0;
            st_nxt.tick = 1'b1;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + 4'h1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign lnk.sar_tick = st_r.tick;
endmodule
`default_nettype wire

// File: hw/adcc_result_fmt.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_result_fmt
    import adcc_pkg::*;
(
    adcc_link_if.fmt lnk
);
    // signed compare for differential words, unsigned otherwise
    function automatic logic above(input logic [15:0] a, input logic [15:0] b, input logic sgn);
        if (sgn)
            return $signed(a) > $signed(b);
        return a > b;
    endfunction

    logic [9:0] code;
    logic       over_gt;
    logic       under_lt;

    always_comb
    begin
        code = lnk.raw;
        if (lnk.diff)
            code[DATA_BITS-1] = ~lnk.raw[DATA_BITS-1];
        if (lnk.ljst)
            lnk.word = {code, 6'h00};
        else
            lnk.word = {{6{lnk.diff & code[DATA_BITS-1]}}, code};
        over_gt  = above(lnk.word, lnk.gt_limit, lnk.diff);
        under_lt = above(lnk.lt_limit, lnk.word, lnk.diff);
        // limits ordered one way give an in-band window, the other way out-of-band
        if (above(lnk.lt_limit, lnk.gt_limit, lnk.diff))
            lnk.hit = over_gt & under_lt;
        else
            lnk.hit = over_gt | under_lt;
    end
endmodule
`default_nettype wire

// File: hw/adcc_top.sv
// Functional notes
// - each pair bit: 0 two single-ended inputs, 1 differential pair, lower input positive
// - sar clock period 1,2,4,8 system clocks for codes 0-3, 16 for 1xx
// - enable 0 means shutdown; 1 means active and accepting conversions
// - track mode 0: track continuously except during a conversion
// - track mode 1: triggered modes track 3 sar clocks; pin mode tracks while low
// - busy write 1 starts only in mode 00; writing 0 does nothing
// - done flag set on completion, held until software clears it
// - window flag set on a window match, held until software clears it
// - justify bit 1 left-justifies the result, else right-justified
// - compare each result against greater-than and less-than limit words
`timescale 1ns/1ps
`default_nettype none
module adcc_top
    import adcc_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   srst,
    input  wire logic [7:0]             sfr_addr,
    input  wire logic                   sfr_wr,
    input  wire logic [7:0]             sfr_wdata,
    output logic [7:0]                  sfr_rdata,
    input  wire logic                   timer2_overflow,
    input  wire logic                   timer3_overflow,
    input  wire logic                   convert_start_pin,
    input  wire logic [2:0]             mux_channel,
    input  wire logic [15:0]            window_gt_limit,
    input  wire logic [15:0]            window_lt_limit,
    input  wire logic                   core_done,
    input  wire logic [adcc_pkg::DATA_BITS-1:0] core_data,
    output logic                        core_powerdown,
    output logic                        core_track,
    output logic                        core_convert_start,
    output logic                        sar_clock_tick,
    output logic [2:0]                  amplifier_gain_select,
    output logic [3:0]                  pair_differential,
    output logic                        conversion_busy,
    output logic                        conversion_done_flag,
    output logic                        window_match_flag,
    output logic [adcc_pkg::WORD_BITS-1:0] result_word,
    output logic                        busy_fall_irq
);
    import adcc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TRACK,
        ST_CONVERT
    } adcc_state_t;

    typedef struct packed {
        adcc_state_t state;
        logic [3:0]  pair_cfg;
        logic [2:0]  sar_code;
        logic [2:0]  gain;
        logic        enable;
        logic        track_mode;
        logic        done;
        logic [1:0]  stm;
        logic        window;
        logic        ljst;
        logic [1:0]  track_cnt;
        logic        pin_prev;
        logic [15:0] result;
        logic [7:0]  rdata;
        logic        start;
        logic        irq;
    } adcc_top_st_t;

    adcc_top_st_t st_r;
    adcc_top_st_t st_nxt;
    adcc_link_if  lnk ();

    logic         wr_ctl;
    logic         wr_cfg;
    logic         wr_pair;
    logic         pin_rise;
    logic         trigger;
    logic         busy;
    logic         finish;
    logic         chan_diff;
    logic [7:0]   ctl_view;
    logic         eff_enable;
    logic         eff_track;
    logic [1:0]   eff_stm;

    // exact match on the full address; no aliasing
    function automatic logic reg_hit(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
        return wr && (addr == ofs);
    endfunction

    // triggered modes run a timed track phase; pin mode tracks on the pin level
    function automatic logic timed_track(input logic tm, input logic [1:0] stm);
        return tm && (stm != STM_PIN);
    endfunction

    // unmapped addresses and reserved bits read back as zero
    function automatic logic [7:0] reg_view(
        input logic [7:0]   addr,
        input adcc_top_st_t s,
        input logic [7:0]   ctl
    );
        logic [7:0] v;
        unique case (addr)
            OFS_PAIR_CFG: v = {4'h0, s.pair_cfg};
            OFS_CONV_CFG: v = {s.sar_code, 2'h0, s.gain};
            OFS_CONV_CTL: v = ctl;
            default:      v = 8'h00;
        endcase
        return v;
    endfunction

    adcc_sar_clkgen u_clkgen (
        .ref_clk (ref_clk),
        .srst    (srst),
        .lnk     (lnk.clkgen)
    );

    adcc_result_fmt u_fmt (
        .lnk (lnk.fmt)
    );

    assign chan_diff     = st_r.pair_cfg[mux_channel[2:1]];
    assign lnk.sar_code  = st_r.sar_code;
    assign lnk.enable    = st_r.enable;
    assign lnk.raw       = core_data;
    assign lnk.diff      = chan_diff;
    assign lnk.ljst      = st_r.ljst;
    assign lnk.gt_limit  = window_gt_limit;
    assign lnk.lt_limit  = window_lt_limit;

    assign busy     = (st_r.state != ST_IDLE);
    assign wr_ctl   = reg_hit(sfr_wr, sfr_addr, OFS_CONV_CTL);
    assign wr_cfg   = reg_hit(sfr_wr, sfr_addr, OFS_CONV_CFG);
    assign wr_pair  = reg_hit(sfr_wr, sfr_addr, OFS_PAIR_CFG);
    assign pin_rise = convert_start_pin && !st_r.pin_prev;
    assign finish   = (st_r.state == ST_CONVERT) && core_done && st_r.enable;

    always_comb
    begin
        // a control write counts in the cycle it lands, so one write may
        // enable, pick the start mode and set the busy bit together
        if (wr_ctl)
        begin
            eff_enable = sfr_wdata[CTL_ENABLE];
            eff_track  = sfr_wdata[CTL_TRACK_MODE];
            eff_stm    = sfr_wdata[CTL_STM_LSB +: 2];
        end
        else
        begin
            eff_enable = st_r.enable;
            eff_track  = st_r.track_mode;
            eff_stm    = st_r.stm;
        end
    end

    always_comb
    begin
        ctl_view = {st_r.enable, st_r.track_mode, st_r.done, busy, st_r.stm, st_r.window, st_r.ljst};
        unique case (eff_stm)
            STM_SOFTWARE: trigger = wr_ctl && sfr_wdata[CTL_BUSY];
            STM_TIMER3:   trigger = timer3_overflow;
            STM_PIN:      trigger = pin_rise;
            STM_TIMER2:   trigger = timer2_overflow;
        endcase
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.start    = 1'b0;
        st_nxt.irq      = 1'b0;
        st_nxt.pin_prev = convert_start_pin;

        if (wr_pair)
            st_nxt.pair_cfg = sfr_wdata[3:0];
        if (wr_cfg)
        begin
            st_nxt.sar_code = sfr_wdata[CFG_SAR_LSB +: 3];
            st_nxt.gain     = sfr_wdata[CFG_GAIN_LSB +: 3];
        end
        if (wr_ctl)
        begin
            st_nxt.enable     = sfr_wdata[CTL_ENABLE];
            st_nxt.track_mode = sfr_wdata[CTL_TRACK_MODE];
            st_nxt.stm        = sfr_wdata[CTL_STM_LSB +: 2];
            st_nxt.ljst       = sfr_wdata[CTL_LJST];
            // software may clear or set the flags; a finishing conversion below wins
            st_nxt.done       = sfr_wdata[CTL_DONE];
            st_nxt.window     = sfr_wdata[CTL_WINDOW];
        end

        unique case (st_r.state)
            ST_IDLE:
            begin
                // triggers arriving while busy are dropped, not queued
                if (eff_enable && trigger)
                begin
                    if (timed_track(eff_track, eff_stm))
                    begin
                        st_nxt.state     = ST_TRACK;
                        st_nxt.track_cnt = 2'h0;
                    end
                    else
                    begin
                        st_nxt.state = ST_CONVERT;
                        st_nxt.start = 1'b1;
                    end
                end
            end
            ST_TRACK:
            begin
                if (lnk.sar_tick)
                begin
                    if (st_r.track_cnt == TRACK_SAR_CLKS - 2'h1)
                    begin
                        st_nxt.state = ST_CONVERT;
                        st_nxt.start = 1'b1;
                    end
                    else
                    begin
                        st_nxt.track_cnt = st_r.track_cnt + 2'h1;
                    end
                end
            end
            ST_CONVERT:
            begin
                if (core_done)
                begin
                    st_nxt.state  = ST_IDLE;
                    st_nxt.result = lnk.word;
                    st_nxt.done   = 1'b1;
                    st_nxt.irq    = 1'b1;
                    if (lnk.hit)
                        st_nxt.window = 1'b1;
                end
            end
        endcase

        // disabling aborts a conversion in flight, unless it finishes that same cycle, without touching the flags
        if (!eff_enable && !finish)
        begin
            st_nxt.state = ST_IDLE;
            // a start pulse queued this cycle must not reach a powered-down core
            st_nxt.start = 1'b0;
        end

        // read data lags the address by one cycle
        st_nxt.rdata = reg_view(sfr_addr, st_r, ctl_view);
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_r            <= '0;
            st_r.state      <= ST_IDLE;
            st_r.pair_cfg   <= RST_PAIR_CFG[3:0];
            st_r.sar_code   <= RST_CONV_CFG[CFG_SAR_LSB +: 3];
            st_r.gain       <= RST_CONV_CFG[CFG_GAIN_LSB +: 3];
            st_r.enable     <= RST_CONV_CTL[CTL_ENABLE];
            st_r.track_mode <= RST_CONV_CTL[CTL_TRACK_MODE];
            st_r.stm        <= RST_CONV_CTL[CTL_STM_LSB +: 2];
            st_r.ljst       <= RST_CONV_CTL[CTL_LJST];
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    always_comb
    begin
        if (!st_r.enable)
            core_track = 1'b0;
        else if (!st_r.track_mode)
            core_track = (st_r.state != ST_CONVERT);
        else if (timed_track(st_r.track_mode, st_r.stm))
            core_track = (st_r.state == ST_TRACK);
        else
            core_track = !convert_start_pin && (st_r.state != ST_CONVERT);
    end

    assign core_powerdown        = !st_r.enable;
    assign core_convert_start    = st_r.start;
    assign sar_clock_tick        = lnk.sar_tick;
    assign amplifier_gain_select = st_r.gain;
    assign pair_differential     = st_r.pair_cfg;
    assign conversion_busy       = busy;
    assign conversion_done_flag  = st_r.done;
    assign window_match_flag     = st_r.window;
    assign result_word           = st_r.result;
    assign busy_fall_irq         = st_r.irq;
    assign sfr_rdata             = st_r.rdata;
endmodule
`default_nettype wire

// File: testbench/adcc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_checker
    import adcc_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       timer2_overflow,
    input wire logic       timer3_overflow,
    input wire logic       convert_start_pin,
    input wire logic       core_done,
    input wire logic       core_powerdown,
    input wire logic       core_track,
    input wire logic       core_convert_start,
    input wire logic [3:0] pair_differential,
    input wire logic       conversion_busy,
    input wire logic       conversion_done_flag,
    input wire logic       window_match_flag,
    input wire logic       busy_fall_irq
);
    logic ctl_wr;
    assign ctl_wr = sfr_wr && sfr_addr == OFS_CONV_CTL;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    property p_sw_go;
        ctl_wr && sfr_wdata == 8'h90 && !conversion_busy |=> conversion_busy && core_convert_start;
    endproperty
    a_sw_go: assert property (p_sw_go) else $error("software start missed");
    property p_trk_go;
        ctl_wr && sfr_wdata == 8'hD0 && !conversion_busy |=> conversion_busy && core_track && !core_convert_start;
    endproperty
    a_trk_go: assert property (p_trk_go) else $error("track phase missed");
    // no trigger of any kind may be pending for this to hold
    property p_zero;
        ctl_wr && !sfr_wdata[CTL_BUSY] && !conversion_busy && !timer2_overflow && !timer3_overflow
            && !convert_start_pin |=> !conversion_busy;
    endproperty
    a_zero: assert property (p_zero) else $error("busy zero write started");
    property p_done;
        core_done && conversion_busy |=> !conversion_busy && conversion_done_flag && busy_fall_irq;
    endproperty
    a_done: assert property (p_done) else $error("completion not in one cycle");
    property p_done_hold;
        conversion_done_flag && !ctl_wr |=> conversion_done_flag;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done flag lost");
    property p_win_hold;
        window_match_flag && !ctl_wr |=> window_match_flag;
    endproperty
    a_win_hold: assert property (p_win_hold) else $error("window flag lost");
    property p_irq;
        busy_fall_irq |-> $fell(conversion_busy);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without busy fall");
    property p_pair;
        sfr_wr && sfr_addr == OFS_PAIR_CFG ##1 !sfr_wr |=> pair_differential == $past(sfr_wdata[3:0], 2);
    endproperty
    a_pair: assert property (p_pair) else $error("pair config not copied");
    property p_off;
        core_powerdown |-> !core_convert_start;
    endproperty
    a_off: assert property (p_off) else $error("start while shut down");
endmodule
bind adcc_top adcc_checker chk_u (.ref_clk(ref_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .timer2_overflow(timer2_overflow), .timer3_overflow(timer3_overflow),
    .convert_start_pin(convert_start_pin), .core_done(core_done), .core_powerdown(core_powerdown),
    .core_track(core_track), .core_convert_start(core_convert_start), .pair_differential(pair_differential),
    .conversion_busy(conversion_busy), .conversion_done_flag(conversion_done_flag),
    .window_match_flag(window_match_flag), .busy_fall_irq(busy_fall_irq));
`default_nettype wire

// File: testbench/adcc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model #(
    parameter int LAT = 12
) (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       start,
    input  wire logic       powerdown,
    input  wire logic [9:0] value,
    output logic            done,
    output logic [9:0]      data
);
    int cnt;
    always_ff @(posedge ref_clk)
    begin
        done <= 1'b0;
        // outside the done cycle the data lines carry no valid word
        data <= srst ? 10'h000 : ~data;
        if (srst || powerdown)
            cnt <= 0;
        else if (start)
            cnt <= LAT;
        else if (cnt > 0)
        begin
            cnt <= cnt - 1;
            done <= cnt == 1;
            if (cnt == 1)
                data <= value;
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb_adc_conversion_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_adc_conversion_control;
    import adcc_pkg::*;
    logic        ref_clk, srst, sfr_wr, timer2_overflow, timer3_overflow, convert_start_pin, core_done;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
    logic [2:0]  mux_channel, amplifier_gain_select;
    logic [15:0] window_gt_limit, window_lt_limit, result_word;
    logic [9:0]  core_data, core_val;
    logic [3:0]  pair_differential;
    logic        core_powerdown, core_track, core_convert_start, sar_clock_tick;
    logic        conversion_busy, conversion_done_flag, window_match_flag, busy_fall_irq;
    int          err_count = 0;
    int          cmp_count = 0;
    int          n, k;
    adcc_top dut_u (.ref_clk(ref_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .timer2_overflow(timer2_overflow), .timer3_overflow(timer3_overflow),
        .convert_start_pin(convert_start_pin), .mux_channel(mux_channel), .window_gt_limit(window_gt_limit),
        .window_lt_limit(window_lt_limit), .core_done(core_done), .core_data(core_data),
        .core_powerdown(core_powerdown), .core_track(core_track), .core_convert_start(core_convert_start),
        .sar_clock_tick(sar_clock_tick), .amplifier_gain_select(amplifier_gain_select),
        .pair_differential(pair_differential), .conversion_busy(conversion_busy),
        .conversion_done_flag(conversion_done_flag), .window_match_flag(window_match_flag),
        .result_word(result_word), .busy_fall_irq(busy_fall_irq));
    adcc_core_model model_u (.ref_clk(ref_clk), .srst(srst), .start(core_convert_start),
        .powerdown(core_powerdown), .value(core_val), .done(core_done), .data(core_data));
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task close_out;
        $display("mismatches %0d of %0d compares", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        sfr_addr = a;
        @(negedge ref_clk);
        `CHK(sfr_rdata, e)
    endtask
    // control write with the trigger for mode m; the write also clears both flags
    task fire(input logic [1:0] m, input logic lj);
        wr(OFS_CONV_CTL, {2'b10, 1'b0, m == STM_SOFTWARE, m, 1'b0, lj});
        timer3_overflow = m == STM_TIMER3;
        timer2_overflow = m == STM_TIMER2;
        convert_start_pin = m == STM_PIN;
        @(negedge ref_clk);
        timer2_overflow = 1'b0;
        timer3_overflow = 1'b0;
        convert_start_pin = 1'b0;
    endtask
    task conv(input logic [9:0] v, input logic [15:0] w, input logic h);
        core_val = v;
        k = 0;
        while (busy_fall_irq !== 1'b1 && k < 200)
        begin
            @(negedge ref_clk);
            k++;
        end
        `CHK(result_word, w)
        `CHK(conversion_done_flag, 1'b1)
        `CHK(window_match_flag, h)
        `CHK(conversion_busy, 1'b0)
    endtask
    initial
    begin
        #(25 * 20000);
        err_count++;
        close_out();
    end
    initial
    begin
        {srst, sfr_wr, sfr_addr, sfr_wdata, timer2_overflow, timer3_overflow, convert_start_pin} = {1'b1, 20'h0};
        {mux_channel, window_gt_limit, window_lt_limit, core_val} = {3'h0, 16'hFFFF, 16'h0000, 10'h000};
        repeat (6) @(negedge ref_clk);
        srst = 1'b0;
        `CHK(core_powerdown, 1'b1)
        rd(OFS_CONV_CTL, RST_CONV_CTL);
        rd(OFS_CONV_CFG, RST_CONV_CFG);
        rd(OFS_PAIR_CFG, RST_PAIR_CFG);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h00);
        wr(OFS_PAIR_CFG, 8'hFF);
        rd(OFS_PAIR_CFG, 8'h0F);
        `CHK(pair_differential, 4'hF)
        wr(OFS_CONV_CFG, 8'hFF);
        rd(OFS_CONV_CFG, 8'hE7);
        `CHK(amplifier_gain_select, 3'h7)
        wr(OFS_PAIR_CFG, 8'h00);
        wr(OFS_CONV_CTL, 8'h80);
        @(negedge ref_clk);
        `CHK(core_powerdown, 1'b0)
        `CHK(core_track, 1'b1)
        for (int c = 0; c < 8; c++)
        begin
            wr(OFS_CONV_CFG, {c[2:0], 5'h00});
            repeat (40) @(negedge ref_clk);
            while (sar_clock_tick !== 1'b1 && n < 40)
                @(negedge ref_clk);
            n = 0;
            do
            begin
                @(negedge ref_clk);
                n++;
            end while (sar_clock_tick !== 1'b1 && n < 40);
            `CHK(n, 1 << (c > 3 ? 4 : c))
        end
        wr(OFS_CONV_CFG, 8'h00);
        fire(STM_SOFTWARE, 1'b0);
        conv(10'h2A5, 16'h02A5, 1'b0);
        rd(OFS_CONV_CTL, 8'hA0);
        fire(STM_SOFTWARE, 1'b1);
        conv(10'h2A5, {10'h2A5, 6'h00}, 1'b0);
        for (int m = 1; m < 4; m++)
        begin
            fire(m[1:0], 1'b0);
            conv(10'h155, 16'h0155, 1'b0);
        end
        wr(OFS_CONV_CTL, 8'h94);
        timer2_overflow = 1'b1;
        @(negedge ref_clk);
        timer2_overflow = 1'b0;
        repeat (3) @(negedge ref_clk);
        `CHK(conversion_busy, 1'b0)
        rd(OFS_CONV_CTL, 8'h84);
        wr(OFS_PAIR_CFG, 8'h01);
        fire(STM_SOFTWARE, 1'b0);
        conv(10'h2A5, 16'h00A5, 1'b0);
        fire(STM_SOFTWARE, 1'b0);
        conv(10'h0A5, 16'hFEA5, 1'b0);
        mux_channel = 3'h2;
        {window_gt_limit, window_lt_limit} = {16'h0100, 16'h0080};
        fire(STM_SOFTWARE, 1'b0);
        conv(10'h200, 16'h0200, 1'b1);
        fire(STM_SOFTWARE, 1'b0);
        conv(10'h0C0, 16'h00C0, 1'b0);
        {window_gt_limit, window_lt_limit} = {16'h0080, 16'h0100};
        fire(STM_SOFTWARE, 1'b0);
        conv(10'h0C0, 16'h00C0, 1'b1);
        wr(OFS_CONV_CTL, 8'hD0);
        k = 0;
        n = int'(core_track === 1'b1);
        while (core_convert_start !== 1'b1 && k < 50)
        begin
            @(negedge ref_clk);
            k++;
            n += core_track === 1'b1;
        end
        `CHK(n >= 3 && n <= 4, 1'b1)
        conv(10'h001, 16'h0001, 1'b0);
        wr(OFS_CONV_CTL, 8'hC8);
        `CHK(core_track, 1'b1)
        convert_start_pin = 1'b1;
        conv(10'h001, 16'h0001, 1'b0);
        `CHK(core_track, 1'b0)
        convert_start_pin = 1'b0;
        wr(OFS_CONV_CTL, 8'h10);
        repeat (3) @(negedge ref_clk);
        `CHK(core_powerdown, 1'b1)
        `CHK(conversion_busy, 1'b0)
        close_out();
    end
endmodule
`default_nettype wire
